// >>> core/unbrp_core.sv
// User nonvolatile byte store with a read-only core port and a test port programming path.
// Assumes one clock; the test port side presents whole bank images with a request pulse.
// Storage has no reset, so it keeps its contents across nrst like the real array.
`default_nettype none

`include "unbrp_defs.svh"

module unbrp_core (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic coreRdEn,
  input wire unbrp_pkg::unbrp_addr_type coreAddr,
  output unbrp_pkg::unbrp_byte_type coreRdData,
  input wire logic tpProgReq,
  input wire unbrp_pkg::unbrp_bank_type tpProgBank,
  input wire logic [`UNBRP_IMG_W-1:0] tpProgImage,
  output logic tpBusy,
  output logic tpDone,
  input wire unbrp_pkg::unbrp_addr_type tpRdAddr,
  output unbrp_pkg::unbrp_byte_type tpRdData
);
  import unbrp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Address helpers.

  // Bank number occupies the top field, byte number the low field of a flat index.
  function automatic unbrp_addr_type entryIndex(input unbrp_bank_type bank,
                                                input unbrp_idx_type idx);
    entryIndex = {bank, idx};
  endfunction : entryIndex

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Storage.

  // 128 entries of one byte give the full 1,024 bits.
  unbrp_byte_type memArr [`UNBRP_ENTRIES];

  unbrp_state_type seqState;
  unbrp_idx_type seqIdx;
  logic seqBusy;
  logic seqDone;

  unbrp_bank_type progBank_r;
  logic [`UNBRP_IMG_W-1:0] progImg_r;

  wire progAccept = tpProgReq && !seqBusy;
  wire seqErase = (seqState == UNBRP_ERASE);
  wire seqWrite = (seqState == UNBRP_WRITE);
  wire wrEn = seqErase || seqWrite;
  wire unbrp_addr_type wrIdx = entryIndex(progBank_r, seqIdx);
  wire unbrp_byte_type imgByte = progImg_r[{seqIdx, 3'h0} +: `UNBRP_BYTE_W];
  wire unbrp_byte_type wrByte = seqErase ? `UNBRP_ERASED : imgByte;

  // The only write path is the sequencer fed by the test port; the core port has no data in.
  genvar g;
  generate
    for (g = 0; g < `UNBRP_ENTRIES; g++) begin : gEntry
      always_ff @(posedge clk_sys) begin
        if (wrEn && (wrIdx == `UNBRP_ADDR_W'(g))) begin
          memArr[g] <= wrByte;
        end
      end

      // Each entry is watched against its own flat index, not against the shared write mux.
      chk_entry_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !(wrEn && (wrIdx == `UNBRP_ADDR_W'(g))) |=> (memArr[g] === $past(memArr[g])))
        else $error("Stored byte changed outside its own programming pass.");

      chk_entry_erase: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (seqErase && (wrIdx == `UNBRP_ADDR_W'(g))) |=> (memArr[g] == `UNBRP_ERASED))
        else $error("Stored byte not erased during the erase sweep.");

      chk_entry_image: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (seqWrite && (wrIdx == `UNBRP_ADDR_W'(g)))
          |=> (memArr[g] ==
               progImg_r[`UNBRP_BYTE_W * (g % `UNBRP_BANK_BYTES) +: `UNBRP_BYTE_W]))
        else $error("Stored byte does not match its place in the bank image.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Test port programming path.

  // A request while busy is dropped; the latched image stays stable for the whole pass.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      progBank_r <= `UNBRP_BANK_RESET;
      progImg_r <= `UNBRP_IMG_RESET;
    end else if (progAccept) begin
      progBank_r <= tpProgBank;
      progImg_r <= tpProgImage;
    end
  end

  unbrp_prog_seq uSeq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(progAccept),
    .state(seqState),
    .byteIdx(seqIdx),
    .busy(seqBusy),
    .done(seqDone)
  );

  assign tpBusy = seqBusy;
  assign tpDone = seqDone;

  // Test port readback of any byte, one cycle after the address is presented.
  unbrp_byte_type tpRdData_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tpRdData_r <= `UNBRP_RD_RESET;
    end else begin
      tpRdData_r <= memArr[tpRdAddr];
    end
  end

  assign tpRdData = tpRdData_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Core read port.

  unbrp_addr_type coreAddr_r;
  logic capFlag_r;
  unbrp_byte_type coreRdData_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      coreAddr_r <= `UNBRP_ADDR_RESET;
      capFlag_r <= 1'b0;
    end else begin
      capFlag_r <= coreRdEn;
      if (coreRdEn) begin
        coreAddr_r <= coreAddr;
      end
    end
  end

  // Loading on the falling edge puts the byte out half a cycle after capture. Loading only
  // after a capture keeps the byte steady even if its bank is reprogrammed meanwhile.
  always_ff @(negedge clk_sys) begin
    if (!nrst) begin
      coreRdData_r <= `UNBRP_RD_RESET;
    end else if (capFlag_r) begin
      coreRdData_r <= memArr[coreAddr_r];
    end
  end

  assign coreRdData = coreRdData_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_addr_capture: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    coreRdEn |=> (coreAddr_r == $past(coreAddr)))
    else $error("Core read address not captured on the rising edge.");

  chk_read_byte: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (coreRdEn && !seqBusy && !tpProgReq) ##1 !$past(tpProgReq)
      |-> (coreRdData_r == memArr[$past(coreAddr)]))
    else $error("Core read data wrong one cycle after capture.");

  chk_bank_field: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    wrEn |-> (wrIdx[`UNBRP_BANK_MSB:`UNBRP_BANK_LSB] == progBank_r))
    else $error("Programming touched a bank other than the selected one.");

  chk_byte_field: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    wrEn |-> (wrIdx[`UNBRP_BYTE_MSB:`UNBRP_BYTE_LSB] == seqIdx))
    else $error("Byte field of the entry index does not follow the byte count.");

  chk_hold_data: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!coreRdEn ##1 !coreRdEn) |=> $stable(coreRdData_r))
    else $error("Core read data changed without a new capture.");

  chk_erase_first: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    progAccept |=> seqErase && (seqIdx == `UNBRP_IDX_FIRST))
    else $error("Programming did not start with an erase of the bank.");

  chk_erase_length: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(seqWrite) |-> $past(seqErase, 16) && $past(seqErase, 1) && (seqIdx == 4'h0))
    else $error("Bank erase did not cover all sixteen bytes.");

  chk_whole_pass: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(seqBusy) |-> !tpDone [*8] ##26 (tpDone && !seqBusy) ##1 !tpDone)
    else $error("Bank pass did not end with done after 33 cycles.");

  chk_no_core_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    wrEn |-> seqBusy && !progAccept)
    else $error("Storage written outside a test port programming pass.");

  chk_busy_ignore: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (tpProgReq && seqBusy) |=> $stable(progBank_r) && $stable(progImg_r))
    else $error("Programming request taken while a pass was running.");

  // Storage starts unknown, so case equality keeps an unprogrammed byte from firing this.
  chk_tp_readback: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> (tpRdData_r === $past(memArr[tpRdAddr])))
    else $error("Test port readback does not match the stored byte.");

  chk_done_after_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(seqWrite) |=> tpDone ##1 !tpDone)
    else $error("Done pulse did not follow the last written byte.");

  chk_refused_start: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (tpProgReq && seqBusy) |=> !(seqErase && (seqIdx == `UNBRP_IDX_FIRST)))
    else $error("A request given while busy restarted the erase sweep.");
endmodule : unbrp_core

`default_nettype wire

// >>> core/unbrp_prog_seq.sv
// Bank programming sequencer: erases sixteen bytes, then writes sixteen bytes.
// Assumes start is a one-cycle pulse given only while busy is low.
`default_nettype none

`include "unbrp_defs.svh"

module unbrp_prog_seq (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  output unbrp_pkg::unbrp_state_type state,
  output unbrp_pkg::unbrp_idx_type byteIdx,
  output logic busy,
  output logic done
);
  import unbrp_pkg::*;

  unbrp_state_type state_r;
  unbrp_state_type state_nxt;
  unbrp_idx_type idx_r;
  logic busy_r;
  logic done_r;

  wire idxLast = (idx_r == `UNBRP_IDX_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UNBRP_IDLE: begin
        if (start) begin
          state_nxt = UNBRP_ERASE;
        end
      end
      UNBRP_ERASE: begin
        if (idxLast) begin
          state_nxt = UNBRP_WRITE;
        end
      end
      UNBRP_WRITE: begin
        if (idxLast) begin
          state_nxt = UNBRP_DONE;
        end
      end
      default: begin
        state_nxt = UNBRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= UNBRP_IDLE;
      idx_r <= `UNBRP_IDX_FIRST;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= (state_nxt == state_r) && (state_r != UNBRP_IDLE) ?
               idx_r + 1'b1 : `UNBRP_IDX_FIRST;
      busy_r <= (state_nxt != UNBRP_IDLE);
      done_r <= (state_r == UNBRP_DONE);
    end
  end

  assign state = state_r;
  assign byteIdx = idx_r;
  assign busy = busy_r;
  assign done = done_r;
endmodule : unbrp_prog_seq

`default_nettype wire

// >>> include/unbrp_defs.svh
// Constants for the user nonvolatile byte read port: sizes, address fields, fill values.
// Assumes it is included once per compilation unit by the package and the design files.
//
// Behaviour
// - Provide a dedicated 1,024-bit user store that keeps contents without power.
// - Contents are read, modified and written through the test port access path.
// - The core port is read-only; core logic can never alter a stored bit.
// - For programming, the store is eight banks of 128 bits, sixteen bytes each.
// - Programming is accepted only through the test port, never from core fabric.
// - Each bank is rewritten alone and always whole; other banks stay untouched.
// - A bank is erased automatically on chip before its new contents are written.
// - The core read address is captured on the rising edge of the read clock.
// - Read data is valid after the falling edge ending the capturing cycle.
// - Each core read returns exactly one byte, byte aligned within the bank.
// - The three top address bits select one of the eight banks.
// - The four low address bits select one of sixteen bytes in the bank.
`ifndef UNBRP_DEFS_SVH
`define UNBRP_DEFS_SVH

`define UNBRP_BITS 1024
`define UNBRP_BANKS 8
`define UNBRP_BANK_BYTES 16
`define UNBRP_ENTRIES 128
`define UNBRP_BYTE_W 8
`define UNBRP_ADDR_W 7
`define UNBRP_IMG_W 128
`define UNBRP_BANK_W 3
`define UNBRP_IDX_W 4
`define UNBRP_BANK_MSB 6
`define UNBRP_BANK_LSB 4
`define UNBRP_BYTE_MSB 3
`define UNBRP_BYTE_LSB 0
`define UNBRP_IDX_LAST 4'hF
`define UNBRP_IDX_FIRST 4'h0
`define UNBRP_ERASED 8'hFF
`define UNBRP_RD_RESET 8'h00
`define UNBRP_ADDR_RESET 7'h00
`define UNBRP_BANK_RESET 3'h0
`define UNBRP_IMG_RESET 128'h0

`endif

// >>> include/unbrp_pkg.sv
// Types shared by the byte read port and its bank programming sequencer.
// Assumes unbrp_defs.svh is on the include path.
`default_nettype none

`include "unbrp_defs.svh"

package unbrp_pkg;
  // Gray coded along idle, erase, write, done.
  typedef enum logic [1:0] {
    UNBRP_IDLE = 2'b00,
    UNBRP_ERASE = 2'b01,
    UNBRP_WRITE = 2'b11,
    UNBRP_DONE = 2'b10
  } unbrp_state_type;

  typedef logic [`UNBRP_BYTE_W-1:0] unbrp_byte_type;
  typedef logic [`UNBRP_ADDR_W-1:0] unbrp_addr_type;
  typedef logic [`UNBRP_BANK_W-1:0] unbrp_bank_type;
  typedef logic [`UNBRP_IDX_W-1:0] unbrp_idx_type;
endpackage : unbrp_pkg

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the user nonvolatile byte read port.
// Assumes the package is compiled first and the reader model is present.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import unbrp_pkg::*;

  logic clk_sys, nrst, tpProgReq, tpBusy, tpDone, coreRdEn, gotValid;
  unbrp_addr_type coreAddr, tpRdAddr;
  unbrp_byte_type coreRdData, tpRdData, gotData;
  unbrp_bank_type tpProgBank;
  logic [127:0] tpProgImage;
  unbrp_byte_type mem [128];
  unbrp_byte_type expQ [$];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  unbrp_core u_unbrp_core (.clk_sys(clk_sys), .nrst(nrst), .coreRdEn(coreRdEn),
    .coreAddr(coreAddr), .coreRdData(coreRdData), .tpProgReq(tpProgReq),
    .tpProgBank(tpProgBank), .tpProgImage(tpProgImage), .tpBusy(tpBusy),
    .tpDone(tpDone), .tpRdAddr(tpRdAddr), .tpRdData(tpRdData));

  unbrp_reader reader (.clk_sys(clk_sys), .coreRdEn(coreRdEn), .coreAddr(coreAddr),
    .coreRdData(coreRdData), .gotValid(gotValid), .gotData(gotData));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  // A refused request aims at the next bank while busy; it must leave no trace.
  task automatic prog(input unbrp_bank_type b, input logic [127:0] img, input bit refuse);
    int n;
    tpProgBank = b;
    tpProgImage = img;
    tpProgReq = 1'b1;
    tpRdAddr = {b, 4'hF};
    tick();
    tpProgReq = 1'b0;
    tpProgImage = ~img;
    check("tpBusy", tpBusy, 1'b1);
    n = 1;
    if (refuse) begin
      tpProgReq = 1'b1;
      tpProgBank = b + 3'h1;
      tick();
      tpProgReq = 1'b0;
      n = 2;
    end
    while (tpDone !== 1'b1 && n < 60) begin
      tick();
      n++;
      if (n == 21) check("tpRdData erased", tpRdData, 8'hFF);
    end
    check("cycles to done", n, 34);
    check("tpBusy at done", tpBusy, 1'b0);
    for (int i = 0; i < 16; i++) mem[{b, i[3:0]}] = img[8*i +: 8];
  endtask : prog

  task automatic readAll;
    for (int a = 0; a < 128; a++) begin
      expQ.push_back(mem[a]);
      reader.read(a[6:0], $urandom_range(2, 0));
    end
  endtask : readAll

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge gotValid) begin
    check("coreRdData", gotData, expQ.pop_front());
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'hA447));
    nrst = 1'b0;
    tpProgReq = 1'b0;
    tpProgBank = 3'h0;
    tpProgImage = 128'h0;
    tpRdAddr = 7'h00;
    repeat (6) tick();
    nrst = 1'b1;
    for (int b = 0; b < 8; b++) begin
      prog(b[2:0], {$urandom, $urandom, $urandom, $urandom}, b == 7);
    end
    readAll();
    prog(3'h5, {$urandom, $urandom, $urandom, $urandom}, 1'b0);
    readAll();
    // Contents must survive a reset in mid-run, as the array is nonvolatile.
    nrst = 1'b0;
    repeat (2) tick();
    check("coreRdData in reset", coreRdData, 8'h00);
    check("tpBusy in reset", tpBusy, 1'b0);
    nrst = 1'b1;
    readAll();
    repeat (4) tick();
    check("pending reads", expQ.size(), 0);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire

// >>> test/unbrp_reader.sv
// Core-side reader model: requests one byte at a time on the read-only port.
// Assumes it is called just after a rising edge of clk_sys.
`default_nettype none

module unbrp_reader (
  input wire logic clk_sys,
  output logic coreRdEn,
  output unbrp_pkg::unbrp_addr_type coreAddr,
  input wire unbrp_pkg::unbrp_byte_type coreRdData,
  output logic gotValid,
  output unbrp_pkg::unbrp_byte_type gotData
);
  timeunit 1ns;
  timeprecision 100ps;
  import unbrp_pkg::*;

  initial begin
    coreRdEn = 1'b0;
    coreAddr = 7'h55;
    gotValid = 1'b0;
    gotData = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A nonzero wait samples late, so the held byte is checked while the address
  // wanders; an idle address is inverted so a stale value cannot pass.
  task automatic read(input unbrp_addr_type a, input int waitCycles);
    coreRdEn = 1'b1;
    coreAddr = a;
    @(posedge clk_sys);
    #1;
    coreRdEn = 1'b0;
    coreAddr = ~a;
    repeat (waitCycles) @(posedge clk_sys);
    @(posedge clk_sys);
    gotData = coreRdData;
    gotValid = 1'b1;
    #1;
    gotValid = 1'b0;
  endtask : read
endmodule : unbrp_reader

`default_nettype wire
